/* hw/trc_defs.vh */
// Constants for the tag reader command handler.
// Included by the command handler and the bench; definitions only.
`ifndef TRC_DEFS_VH
`define TRC_DEFS_VH
// Register byte offsets
`define TRC_CTRL_OFS 8'h00
`define TRC_STATUS_OFS 8'h04
`define TRC_CMD_OFS 8'h08
`define TRC_PARAM_OFS 8'h0C
`define TRC_RESULT_OFS 8'h10
`define TRC_ADDR_OFS 8'h14
`define TRC_DUMP_OFS 8'h18
// Command codes
`define TRC_CMD_STATE 3'h1
`define TRC_CMD_READ 3'h2
`define TRC_CMD_INIT 3'h3
`define TRC_CMD_RST 3'h4
`define TRC_CMD_VERSION 3'h5
`define TRC_CMD_DUMP 3'h6
`define TRC_CMD_SAVE 3'h7
// Reply kinds
`define TRC_REP_STATE 3'h1
`define TRC_REP_TAG 3'h2
`define TRC_REP_BOOT 3'h3
`define TRC_REP_VERSION 3'h4
`define TRC_REP_DUMP 3'h5
`define TRC_REP_OK 3'h6
`define TRC_REP_ERR 3'h7
// Parameter indices
`define TRC_P_TYPE 3'h0
`define TRC_P_IDCNT 3'h1
`define TRC_P_OVLP 3'h2
`define TRC_P_QN 3'h3
`define TRC_P_QR 3'h4
`define TRC_P_TMO 3'h5
// Defaults and maxima
`define TRC_DEF_TYPE 8'h01
`define TRC_DEF_IDCNT 8'h01
`define TRC_DEF_OVLP 8'h01
`define TRC_DEF_QN 8'h02
`define TRC_DEF_QR 8'h02
`define TRC_DEF_TMO 8'h05
`define TRC_MAX_IDCNT 8'h01
`define TRC_MAX_OVLP 8'h02
`define TRC_MAX_Q 8'h02
`define TRC_MODE 8'h02
// Timeout step per unit in ms, and clock rate
`define TRC_TMO_STEP_MS 100
`define TRC_CLK_HZ 25000000
// Fields
`define TRC_CARRIAGE_RET 8'h0D
`define TRC_ERR_NOREAD 8'hE1
`define TRC_ERR_RANGE 8'hE2
`define TRC_ERR_LINK 8'hE3
`endif

/* hw/trc_param_mem.v */
// Eight-entry parameter store with registered read port.
// Assumes one writer; reads appear one cycle after the address.
`timescale 1ns/100ps
module trc_param_mem #(
    parameter DEPTH = 8
) (
    input wire clk,
    input wire [2:0] wrAddr,
    input wire [7:0] wrData,
    input wire wrEn,
    input wire [2:0] rdAddr,
    output reg [7:0] rdData
);
    reg [7:0] mem [0:DEPTH-1];

    // Write then registered read
    always @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule // trc_param_mem

/* hw/trc_command_handler.v */
// Command handler: fieldbus link state, reader commands, parameters.
// Assumes link status and tag reads come from same-clock logic, node address pins are asynchronous.
// Functional notes
// - One slave configuration only; no device-specific user parameter data accepted.
// - Successful parametrization makes device ready and lights the run indicator.
// - Link-fail indicator off in data exchange, lit on error.
// - Single mode 2; every read cycle started by master trigger.
// - Only a reduced command and parameter set accepted.
// - Diagnosis replies with current state or error message.
// - Read-tag performs a transponder read, answers with tag number.
// - Load-defaults restores config, restart restarts; both answer boot message with CR.
// - Version query, parameter dump listing, save answers ok.
// - Tag type accepts 1 or 2, default 1.
// - Identical-ID count accepts 0 or 1, default 1.
// - Telegram overlap accepts 0 to 2, default 1.
// - Both digital output parameters accept 0 to 2, default 2.
// - Read timeout accepts 0 to 255, default 5 meaning 500 ms.
// - After a read, tag code or error code is readable.
// - Link-fail lit until configured, parametrized and exchanging data; run lit once parametrized.
// - New node address takes effect only after reset.
`timescale 1ns/100ps
`include "trc_defs.vh"
module trc_command_handler #(
    parameter TAG_W = 32,
    parameter TMO_STEP_CYCLES = (`TRC_CLK_HZ / 1000) * `TRC_TMO_STEP_MS,
    parameter [31:0] VERSION_CODE = 32'h0001_0000 // Arbitrary value
) (
    input wire clk,
    input wire resetn,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hsel,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire linkConfigOk,
    input wire linkParamOk,
    input wire linkUserPrm,
    input wire linkDataExchange,
    input wire [6:0] nodeAddrPins,
    output reg readStart,
    input wire readDone,
    input wire readOk,
    input wire [TAG_W-1:0] readTag,
    output reg [7:0] tagTypeOut,
    output reg [7:0] idCountOut,
    output reg [7:0] overlapOut,
    output reg runLed,
    output reg linkFailLed,
    output reg noReadOut,
    output reg readOut
);
    // FSM states
    localparam ST_IDLE = 2'd0;
    localparam ST_READ = 2'd1;
    localparam ST_DUMP = 2'd2;

    // Range check for bus parameter writes
    function legal;
        input [2:0] idx;
        input [7:0] v;
        begin
            case (idx)
                `TRC_P_TYPE: legal = (v == 8'h01) || (v == 8'h02);
                `TRC_P_IDCNT: legal = (v <= `TRC_MAX_IDCNT);
                `TRC_P_OVLP: legal = (v <= `TRC_MAX_OVLP);
                `TRC_P_QN: legal = (v <= `TRC_MAX_Q);
                `TRC_P_QR: legal = (v <= `TRC_MAX_Q);
                `TRC_P_TMO: legal = 1'b1;
                default: legal = 1'b0;
            endcase
        end
    endfunction

    function [7:0] defval;
        input [2:0] idx;
        begin
            case (idx)
                `TRC_P_TYPE: defval = `TRC_DEF_TYPE;
                `TRC_P_IDCNT: defval = `TRC_DEF_IDCNT;
                `TRC_P_OVLP: defval = `TRC_DEF_OVLP;
                `TRC_P_QN: defval = `TRC_DEF_QN;
                `TRC_P_QR: defval = `TRC_DEF_QR;
                default: defval = `TRC_DEF_TMO;
            endcase
        end
    endfunction

    // Bus address phase capture
    reg wrPend_reg;
    reg rdPend_reg;
    reg [7:0] addr_reg;
    wire take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1; // Zero wait states
    assign hresp = 1'b0;
    always @(posedge clk) begin
        if (!resetn) begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            wrPend_reg <= take && hwrite;
            rdPend_reg <= take && !hwrite;
            if (take) begin
                addr_reg <= haddr[7:0];
            end
        end
    end

    // Node address pins through two flops, latched once after reset
    reg [6:0] nodeSync1_reg;
    reg [6:0] nodeSync2_reg;
    reg [6:0] nodeAddr_reg;
    reg [1:0] capCnt_reg;
    always @(posedge clk) begin
        nodeSync1_reg <= nodeAddrPins;
        nodeSync2_reg <= nodeSync1_reg;
        if (!resetn) begin
            capCnt_reg <= 2'd0;
            nodeAddr_reg <= 7'h00;
        end else if (capCnt_reg != 2'd3) begin
            capCnt_reg <= capCnt_reg + 2'd1;
            if (capCnt_reg == 2'd2) begin
                nodeAddr_reg <= nodeSync2_reg;
            end
        end
    end

    // Link state: user data refused, single configuration
    wire linkUp = linkConfigOk && linkParamOk && !linkUserPrm;
    wire exch = linkUp && linkDataExchange;
    always @(posedge clk) begin
        if (!resetn) begin
            runLed <= 1'b0;
            linkFailLed <= 1'b1;
        end else begin
            runLed <= linkUp;
            linkFailLed <= !exch;
        end
    end

    // Parameter shadow copies and backing store
    reg [7:0] par_reg [0:5];
    reg [2:0] memWrAddr;
    reg [7:0] memWrData;
    reg memWrEn;
    reg [2:0] memRdAddr;
    wire [7:0] memRdData;
    trc_param_mem #(.DEPTH(8)) u_mem (
        .clk(clk),
        .wrAddr(memWrAddr),
        .wrData(memWrData),
        .wrEn(memWrEn),
        .rdAddr(memRdAddr),
        .rdData(memRdData)
    );

    // Command engine registers
    reg [1:0] state_reg;
    reg busy_reg;
    reg done_reg;
    reg rangeErr_reg;
    reg [2:0] reply_reg;
    reg [31:0] result_reg;
    reg [31:0] dump_reg;
    reg [2:0] idx_reg;
    reg [31:0] tmo_reg;
    reg lastOk_reg;
    reg haveRead_reg;
    reg restart_reg;
    wire wr = wrPend_reg && exch;
    wire cmdWr = wr && (addr_reg == `TRC_CMD_OFS);
    wire parWr = wr && (addr_reg == `TRC_PARAM_OFS);
    wire [2:0] cmd = hwdata[2:0];
    wire crOk = (hwdata[15:8] == `TRC_CARRIAGE_RET);
    wire [2:0] pIdx = hwdata[10:8];
    wire [7:0] pVal = hwdata[7:0];
    wire [31:0] tmoCycles = par_reg[`TRC_P_TMO] * TMO_STEP_CYCLES;
    integer i;

    // Command engine
    always @(posedge clk) begin
        readStart <= 1'b0;
        memWrEn <= 1'b0;
        if (!resetn || restart_reg) begin
            for (i = 0; i < 6; i = i + 1) begin
                par_reg[i] <= defval(i[2:0]);
            end
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            done_reg <= restart_reg; // Boot reply after warm start
            rangeErr_reg <= 1'b0;
            reply_reg <= restart_reg ? `TRC_REP_BOOT : 3'd0;
            result_reg <= restart_reg ? {24'h0000_00, `TRC_CARRIAGE_RET} : 32'h0000_0000;
            dump_reg <= 32'h0000_0000;
            idx_reg <= 3'd0;
            tmo_reg <= 32'h0000_0000;
            lastOk_reg <= 1'b0;
            haveRead_reg <= 1'b0;
            restart_reg <= 1'b0;
            memWrAddr <= 3'd0;
            memWrData <= 8'h00;
            memRdAddr <= 3'd0;
        end else begin
            // Result read clears done, unless a completion lands now
            if (rdPend_reg && addr_reg == `TRC_RESULT_OFS) begin
                done_reg <= 1'b0;
            end
            // Parameter writes, only when idle
            if (parWr && !busy_reg) begin
                if (legal(pIdx, pVal)) begin
                    par_reg[pIdx] <= pVal;
                end else begin
                    rangeErr_reg <= 1'b1;
                end
            end
            case (state_reg)
                ST_IDLE: begin
                    if (cmdWr && !busy_reg) begin
                        done_reg <= 1'b0;
                        case (cmd)
                            `TRC_CMD_STATE: begin
                                reply_reg <= rangeErr_reg ? `TRC_REP_ERR : `TRC_REP_STATE;
                                result_reg <= rangeErr_reg ? {24'h0000_00, `TRC_ERR_RANGE} :
                                    {8'h00, `TRC_MODE, 7'h00, haveRead_reg, 7'h00, lastOk_reg};
                                rangeErr_reg <= 1'b0;
                                done_reg <= 1'b1;
                            end
                            `TRC_CMD_READ: begin
                                if (crOk) begin
                                    readStart <= 1'b1;
                                    busy_reg <= 1'b1;
                                    tmo_reg <= tmoCycles;
                                    state_reg <= ST_READ;
                                end else begin
                                    reply_reg <= `TRC_REP_ERR;
                                    done_reg <= 1'b1;
                                end
                            end
                            `TRC_CMD_INIT, `TRC_CMD_RST: begin
                                restart_reg <= 1'b1;
                            end
                            `TRC_CMD_VERSION: begin
                                reply_reg <= `TRC_REP_VERSION;
                                result_reg <= VERSION_CODE;
                                done_reg <= 1'b1;
                            end
                            `TRC_CMD_DUMP: begin
                                dump_reg <= {par_reg[3], par_reg[2], par_reg[1], par_reg[0]};
                                result_reg <= {16'h0000, par_reg[5], par_reg[4]};
                                reply_reg <= `TRC_REP_DUMP;
                                done_reg <= 1'b1;
                            end
                            `TRC_CMD_SAVE: begin
                                busy_reg <= 1'b1;
                                idx_reg <= 3'd0;
                                state_reg <= ST_DUMP;
                            end
                            default: begin
                                reply_reg <= `TRC_REP_ERR;
                                done_reg <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_READ: begin
                    tmo_reg <= tmo_reg - 32'd1;
                    if (readDone || tmo_reg == 32'd0) begin
                        busy_reg <= 1'b0;
                        done_reg <= 1'b1;
                        haveRead_reg <= 1'b1;
                        lastOk_reg <= readDone && readOk;
                        reply_reg <= (readDone && readOk) ? `TRC_REP_TAG : `TRC_REP_ERR;
                        result_reg <= (readDone && readOk) ? readTag[31:0] : {24'h0000_00, `TRC_ERR_NOREAD};
                        state_reg <= ST_IDLE;
                    end
                end
                ST_DUMP: begin
                    // Save walks the six values into the store
                    memWrEn <= 1'b1;
                    memWrAddr <= idx_reg;
                    memWrData <= par_reg[idx_reg];
                    memRdAddr <= idx_reg;
                    idx_reg <= idx_reg + 3'd1;
                    if (idx_reg == 3'd5) begin
                        busy_reg <= 1'b0;
                        done_reg <= 1'b1;
                        reply_reg <= `TRC_REP_OK;
                        result_reg <= 32'h0000_4F4B;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Parameter outputs and digital outputs
    always @(posedge clk) begin
        if (!resetn) begin
            tagTypeOut <= `TRC_DEF_TYPE;
            idCountOut <= `TRC_DEF_IDCNT;
            overlapOut <= `TRC_DEF_OVLP;
            noReadOut <= 1'b0;
            readOut <= 1'b0;
        end else begin
            tagTypeOut <= par_reg[`TRC_P_TYPE];
            idCountOut <= par_reg[`TRC_P_IDCNT];
            overlapOut <= par_reg[`TRC_P_OVLP];
            // 0 off, 1 on, 2 follows last read
            noReadOut <= (par_reg[`TRC_P_QN] == 8'h02) ? (haveRead_reg && !lastOk_reg) :
                par_reg[`TRC_P_QN][0];
            readOut <= (par_reg[`TRC_P_QR] == 8'h02) ? lastOk_reg : par_reg[`TRC_P_QR][0];
        end
    end

    // Read mux, registered into the data phase
    always @(posedge clk) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            case (haddr[7:0])
                `TRC_CTRL_OFS: hrdata <= {24'h0000_00, `TRC_MODE};
                `TRC_STATUS_OFS: hrdata <= {16'h0000, 1'b0, nodeAddr_reg, rangeErr_reg, reply_reg,
                    runLed, linkFailLed, busy_reg, done_reg};
                `TRC_RESULT_OFS: hrdata <= result_reg;
                `TRC_ADDR_OFS: hrdata <= {25'h000_0000, nodeAddr_reg};
                `TRC_DUMP_OFS: hrdata <= dump_reg;
                `TRC_PARAM_OFS: hrdata <= {24'h0000_00, memRdData};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // trc_command_handler

/* test/trc_reader_model.sv */
// Transponder front end model: answers each read start after a set delay.
// Assumes readStart is a one-cycle pulse; delay 8'hFF means no answer at all.
`timescale 1ns/100ps
module trc_reader_model (
    input wire logic clk,
    input wire logic readStart,
    input wire logic [7:0] delay,
    input wire logic okIn,
    input wire logic [31:0] tagIn,
    output logic readDone,
    output logic readOk,
    output logic [31:0] readTag
);
    logic [8:0] cnt = 9'h1FF;
    initial begin
        readDone = 1'b0;
        readOk = 1'b0;
        readTag = 32'h0000_0000;
    end
    // Result lines churn outside the answer cycle so stale values never pass
    always @(posedge clk) begin
        readDone <= 1'b0;
        readOk <= ~readOk;
        readTag <= ~readTag;
        if (readStart && delay != 8'hFF) cnt <= {1'b0, delay};
        else if (cnt != 9'h1FF) cnt <= cnt - 9'h001;
        if (cnt == 9'h000) begin
            readDone <= 1'b1;
            readOk <= okIn;
            readTag <= tagIn;
        end
    end
endmodule // trc_reader_model

/* test/trc_command_handler_asserts.sv */
// Port-level checks of the command handler: indicators, read start, parameters.
// Bound to the handler; sees its ports only.
`timescale 1ns/100ps
module trc_command_handler_asserts (
    input wire clk,
    input wire resetn,
    input wire hreadyout,
    input wire hresp,
    input wire linkConfigOk,
    input wire linkParamOk,
    input wire linkUserPrm,
    input wire linkDataExchange,
    input wire readStart,
    input wire readDone,
    input wire readOk,
    input wire [7:0] tagTypeOut,
    input wire [7:0] idCountOut,
    input wire [7:0] overlapOut,
    input wire runLed,
    input wire linkFailLed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Indicators follow the link state one cycle late
    a_run_led: assert property ($past(resetn) |->
        runLed == $past(linkConfigOk && linkParamOk && !linkUserPrm))
        else $error("run indicator wrong");
    a_user_prm: assert property (linkUserPrm |=> !runLed)
        else $error("run lit with user data");
    a_fail_led: assert property ($past(resetn) |-> linkFailLed ==
        !$past(linkConfigOk && linkParamOk && !linkUserPrm && linkDataExchange))
        else $error("fail indicator wrong");
    a_reset_state: assert property ($rose(resetn) |-> !runLed && linkFailLed && tagTypeOut == 8'h01)
        else $error("reset state wrong");
    // Reads only start while the run indicator is lit
    a_start_link: assert property (readStart |-> runLed)
        else $error("read started with link down");
    a_start_pulse: assert property (readStart |=> !readStart)
        else $error("read start not a pulse");
    a_type_range: assert property (tagTypeOut == 8'h01 || tagTypeOut == 8'h02)
        else $error("tag type out of range");
    a_idcnt_range: assert property (idCountOut <= 8'h01)
        else $error("id count out of range");
    a_overlap_range: assert property (overlapOut <= 8'h02)
        else $error("overlap out of range");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or error");
    c_start: cover property (readStart);
    c_noread: cover property (readDone && !readOk);
    c_run: cover property (runLed && !linkFailLed);
endmodule // trc_command_handler_asserts
bind trc_command_handler trc_command_handler_asserts trc_command_handler_asserts_i (.clk(clk), .resetn(resetn),
    .hreadyout(hreadyout), .hresp(hresp), .linkConfigOk(linkConfigOk), .linkParamOk(linkParamOk),
    .linkUserPrm(linkUserPrm), .linkDataExchange(linkDataExchange), .readStart(readStart), .readDone(readDone),
    .readOk(readOk), .tagTypeOut(tagTypeOut), .idCountOut(idCountOut), .overlapOut(overlapOut), .runLed(runLed),
    .linkFailLed(linkFailLed));

/* test/tb_top.sv */
// Bench: register bus master, link stimulus, reader model, random parameters.
// Assumes zero-wait register answers; timeout step shortened to ten cycles.
`timescale 1ns/100ps
`include "trc_defs.vh"
module tb_top;
    localparam logic [31:0] VERSION_VAL = 32'h00A5_0003; // Arbitrary value
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic hsel = 1'b0;
    logic cfgOk = 1'b0;
    logic prmOk = 1'b0;
    logic userPrm = 1'b0;
    logic dataEx = 1'b0;
    logic [6:0] nodeAddr = 7'h15;
    logic [7:0] delay = 8'h03;
    logic okIn = 1'b1;
    logic [31:0] tagIn = 32'h0000_0000;
    wire hrdy, hresp, readStart, readDone, readOk, runLed, linkFailLed, noReadOut, readOut;
    wire [31:0] hrdata, readTag;
    wire [7:0] tagTypeOut, idCountOut, overlapOut;
    integer seed = 62043;
    integer failures = 0;
    integer cmp_count = 0;
    integer cyc = 0;
    logic [7:0] par [0:5];
    logic [31:0] r, st;
    // Boundary writes as {index, value}
    logic [15:0] edges [0:11] = '{16'h0000, 16'h0003, 16'h0002, 16'h0102, 16'h0100, 16'h0203,
        16'h0202, 16'h0303, 16'h0300, 16'h0403, 16'h0401, 16'h05FF};

    trc_command_handler #(.TMO_STEP_CYCLES(10), .VERSION_CODE(VERSION_VAL)) trc_command_handler_i (
        .clk(clk), .resetn(resetn), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hsel(hsel), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
        .linkConfigOk(cfgOk), .linkParamOk(prmOk), .linkUserPrm(userPrm), .linkDataExchange(dataEx),
        .nodeAddrPins(nodeAddr), .readStart(readStart), .readDone(readDone), .readOk(readOk),
        .readTag(readTag), .tagTypeOut(tagTypeOut), .idCountOut(idCountOut), .overlapOut(overlapOut),
        .runLed(runLed),
        .linkFailLed(linkFailLed), .noReadOut(noReadOut), .readOut(readOut));
    trc_reader_model trc_reader_model_i (.clk(clk), .readStart(readStart), .delay(delay), .okIn(okIn),
        .tagIn(tagIn), .readDone(readDone), .readOk(readOk), .readTag(readTag)); // Single reader

    always #20 clk = ~clk;
    // Watchdog well above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures = failures + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One single transfer; holds each phase until hready is seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        hsel <= 1'b1;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    // Command, poll done, fetch result
    task automatic cmd(input logic [2:0] c, input logic [7:0] cr, output logic [31:0] q);
        integer n;
        bus(1'b1, `TRC_CMD_OFS, {16'h0000, cr, 5'h00, c}, q);
        n = 0;
        st = 32'h0000_0000;
        while (st[0] !== 1'b1 && n < 300) begin
            bus(1'b0, `TRC_STATUS_OFS, 32'h0000_0000, st);
            n = n + 1;
        end
        bus(1'b0, `TRC_RESULT_OFS, 32'h0000_0000, q);
    endtask
    function automatic logic legal(input logic [2:0] i, input logic [7:0] v);
        case (i)
            3'h0: legal = v == 8'h01 || v == 8'h02;
            3'h1: legal = v <= 8'h01;
            3'h2, 3'h3, 3'h4: legal = v <= 8'h02;
            default: legal = 1'b1;
        endcase
    endfunction
    function automatic logic [2:0] kind(input logic [2:0] c);
        case (c)
            3'h1: kind = `TRC_REP_STATE;
            3'h2: kind = `TRC_REP_TAG;
            3'h3, 3'h4: kind = `TRC_REP_BOOT;
            3'h5: kind = `TRC_REP_VERSION;
            3'h6: kind = `TRC_REP_DUMP;
            default: kind = `TRC_REP_OK;
        endcase
    endfunction
    task automatic setp(input logic [2:0] i, input logic [7:0] v);
        bus(1'b1, `TRC_PARAM_OFS, {21'h00_0000, i, v}, r);
        if (legal(i, v)) par[i] = v;
    endtask
    // Dump word only refreshes on the dump command, which answers {timeout, read output}
    task automatic chkpar();
        cmd(`TRC_CMD_DUMP, 8'h00, r);
        chk(r, {16'h0000, par[5], par[4]});
        bus(1'b0, `TRC_DUMP_OFS, 32'h0000_0000, r);
        chk(r, {par[3], par[2], par[1], par[0]});
        chk({8'h00, tagTypeOut, idCountOut, overlapOut}, {8'h00, par[0], par[1], par[2]});
    endtask

    initial begin
        integer i, t0;
        logic [31:0] v;
        par = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h02, 8'h05};
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        // Link down: write refused, mode and address readable
        chk({30'h0, runLed, linkFailLed}, 32'h0000_0001);
        bus(1'b1, `TRC_PARAM_OFS, 32'h0000_0002, r);
        bus(1'b0, `TRC_CTRL_OFS, 32'h0000_0000, r);
        chk(r, {24'h00_0000, `TRC_MODE});
        bus(1'b0, `TRC_ADDR_OFS, 32'h0000_0000, r);
        chk(r, 32'h0000_0015);
        nodeAddr <= 7'h2A;
        cfgOk <= 1'b1;
        prmOk <= 1'b1;
        userPrm <= 1'b1;
        repeat (3) @(posedge clk);
        chk({30'h0, runLed, linkFailLed}, 32'h0000_0001);
        userPrm <= 1'b0;
        dataEx <= 1'b1;
        repeat (3) @(posedge clk);
        chk({30'h0, runLed, linkFailLed}, 32'h0000_0002);
        bus(1'b0, `TRC_ADDR_OFS, 32'h0000_0000, r);
        chk(r, 32'h0000_0015);
        chkpar();
        // Random then boundary parameter writes
        for (i = 0; i < 24; i++) begin
            v = $unsigned($random(seed)) % 6;
            setp(v[2:0], $random(seed));
        end
        chkpar();
        for (i = 0; i < 12; i++) setp(edges[i][10:8], edges[i][7:0]);
        chkpar();
        bus(1'b0, `TRC_STATUS_OFS, 32'h0000_0000, st);
        chk({31'h0, st[7]}, 32'h0000_0001);
        cmd(`TRC_CMD_STATE, 8'h00, r);
        chk({st[6:4], r[7:0]}, {`TRC_REP_ERR, `TRC_ERR_RANGE});
        // Every command but read, with its reply
        for (i = 1; i < 8; i++) begin
            if (i == 2) continue;
            cmd(i[2:0], 8'h00, r);
            chk({29'h0, st[6:4]}, {29'h0, kind(i[2:0])});
            if (i == 3 || i == 4) begin
                par = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h02, 8'h05};
                chk(r, {24'h00_0000, `TRC_CARRIAGE_RET});
                chkpar();
            end
            if (i == 5) chk(r, VERSION_VAL);
            if (i == 6) chk(r, {16'h0000, par[5], par[4]});
            if (i == 7) chk(r, 32'h0000_4F4B);
        end
        // Good read, missing terminator, no answer, zero timeout
        tagIn <= $random(seed);
        cmd(`TRC_CMD_READ, `TRC_CARRIAGE_RET, r);
        chk(r, tagIn);
        chk({30'h0, readOut, noReadOut}, 32'h0000_0002);
        cmd(`TRC_CMD_READ, 8'h00, r);
        chk({29'h0, st[6:4]}, {29'h0, `TRC_REP_ERR});
        delay <= 8'hFF;
        t0 = cyc;
        cmd(`TRC_CMD_READ, `TRC_CARRIAGE_RET, r);
        chk(r, {24'h00_0000, `TRC_ERR_NOREAD});
        chk({31'h0, cyc - t0 >= 50}, 32'h0000_0001);
        chk({30'h0, readOut, noReadOut}, 32'h0000_0001);
        setp(3'h5, 8'h00);
        setp(3'h3, 8'h00);
        setp(3'h4, 8'h01);
        cmd(`TRC_CMD_READ, `TRC_CARRIAGE_RET, r);
        chk(r, {24'h00_0000, `TRC_ERR_NOREAD});
        chk({30'h0, readOut, noReadOut}, 32'h0000_0002);
        // Reset in mid-run: new address and defaults
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        par = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h02, 8'h05};
        chkpar();
        bus(1'b0, `TRC_ADDR_OFS, 32'h0000_0000, r);
        chk(r, 32'h0000_002A);
        report_and_stop();
    end
endmodule // tb_top
